// *** rtl/turb_pkg.sv ***
// constants for the upper configuration register bank of the transceiver
package turb_pkg;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned DATA_W = 8;

    // register offsets
    localparam logic [6:0] ADR_DATA_PORT   = 7'h00;
    localparam logic [6:0] ADR_OP_MODE     = 7'h01;
    localparam logic [6:0] ADR_RATE_MSB    = 7'h02;
    localparam logic [6:0] ADR_RATE_LSB    = 7'h03;
    localparam logic [6:0] ADR_FLAGS       = 7'h3f;
    localparam logic [6:0] ADR_PIN_MAP_LO  = 7'h40;
    localparam logic [6:0] ADR_PIN_MAP_HI  = 7'h41;
    localparam logic [6:0] ADR_REVISION    = 7'h42;
    localparam logic [6:0] ADR_GAIN_REF    = 7'h43;
    localparam logic [6:0] ADR_GAIN_THR1   = 7'h44;
    localparam logic [6:0] ADR_GAIN_THR2   = 7'h45;
    localparam logic [6:0] ADR_GAIN_THR3   = 7'h46;
    localparam logic [6:0] ADR_REF_SELECT  = 7'h58;
    localparam logic [6:0] ADR_HP_AMP      = 7'h5a;
    localparam logic [6:0] ADR_SYNTH_BW    = 7'h5c;
    localparam logic [6:0] ADR_LOW_NOISE_BW = 7'h5e;
    localparam logic [6:0] ADR_CAL_TEMP    = 7'h6c;
    localparam logic [6:0] ADR_RATE_FRAC   = 7'h70;

    // reset values
    localparam logic [7:0] RST_OP_MODE     = 8'h01;
    localparam logic [7:0] RST_RATE_MSB    = 8'h1a;
    localparam logic [7:0] RST_RATE_LSB    = 8'h0b;
    localparam logic [7:0] RST_FLAGS       = 8'h40;
    localparam logic [7:0] RST_PIN_MAP     = 8'h00;
    localparam logic [7:0] RST_GAIN_REF    = 8'hd3;
    localparam logic [7:0] RST_GAIN_THR1   = 8'h0e;
    localparam logic [7:0] RST_GAIN_THR2   = 8'h5b;
    localparam logic [7:0] RST_GAIN_THR3   = 8'hdb;
    localparam logic [7:0] RST_REF_SELECT  = 8'h09;
    localparam logic [7:0] RST_HP_AMP      = 8'h84;
    localparam logic [7:0] RST_PLL_BW      = 8'hd0;
    localparam logic [7:0] RST_CAL_TEMP    = 8'h00;
    localparam logic [7:0] RST_RATE_FRAC   = 8'h00;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;

    // arbitrary neutral revision code
    localparam logic [7:0] REVISION_CODE   = 8'h1c;

    // operating-mode field layout and write mask (bit 7 unused)
    localparam int unsigned MOD_HI   = 6;
    localparam int unsigned MOD_LO   = 5;
    localparam int unsigned SHAPE_HI = 4;
    localparam int unsigned SHAPE_LO = 3;
    localparam int unsigned MODE_HI  = 2;
    localparam int unsigned MODE_LO  = 0;
    localparam logic [7:0] OP_MODE_MASK = 8'h7f;
    // fraction uses low nibble only
    localparam logic [7:0] FRAC_MASK    = 8'h0f;

    // flag bit positions; sticky ones clear by writing one
    localparam int unsigned FLG_FULL     = 7;
    localparam int unsigned FLG_EMPTY    = 6;
    localparam int unsigned FLG_LEVEL    = 5;
    localparam int unsigned FLG_OVERRUN  = 4;
    localparam int unsigned FLG_SENT     = 3;
    localparam int unsigned FLG_READY    = 2;
    localparam int unsigned FLG_CRC_OK   = 1;
    localparam int unsigned FLG_LOW_BAT  = 0;
    localparam logic [7:0] FLG_STICKY    = 8'h11;

    // bit-rate accumulator works in sixteenths of a clock
    localparam int unsigned ACC_W        = 21;
    localparam logic [20:0] ACC_STEP     = 21'h000010;

    typedef enum logic [1:0] {
        TURB_MOD_FSK   = 2'b00,
        TURB_MOD_OOK   = 2'b01,
        TURB_MOD_RSV2  = 2'b10,
        TURB_MOD_RSV3  = 2'b11
    } turb_mod_t;

    typedef enum logic [2:0] {
        TURB_SLEEP     = 3'b000,
        TURB_STANDBY   = 3'b001,
        TURB_TX_SYNTH  = 3'b010,
        TURB_TRANSMIT  = 3'b011,
        TURB_RX_SYNTH  = 3'b100,
        TURB_RECEIVE   = 3'b101
    } turb_mode_t;
endpackage

// *** rtl/turb_regs.sv ***
// upper configuration register bank with data port, flags and bit-rate tick
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module turb_regs
    import turb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    input  wire logic [6:0]  addr,
    input  wire logic [7:0]  wr_data,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [7:0]  rd_data,
    output logic             tx_push,
    output logic      [7:0]  tx_byte,
    output logic             rx_pop,
    input  wire logic [7:0]  rx_byte,
    input  wire logic [7:0]  flag_in,
    input  wire logic        cal_done,
    input  wire logic [7:0]  cal_temp_in,
    output logic      [1:0]  modulation_kind,
    output logic      [1:0]  pulse_shaping_select,
    output logic      [2:0]  xcvr_mode,
    output logic             mode_written,
    output logic      [7:0]  pin_map_low,
    output logic      [7:0]  pin_map_high_clock_out,
    output logic      [7:0]  gain_control_reference,
    output logic      [7:0]  gain_threshold_one,
    output logic      [7:0]  gain_threshold_two,
    output logic      [7:0]  gain_threshold_three,
    output logic      [7:0]  reference_input_select,
    output logic      [7:0]  high_power_amp_setting,
    output logic      [7:0]  synth_loop_bandwidth,
    output logic      [7:0]  low_noise_loop_bandwidth,
    output logic             bit_tick
);
    logic [7:0]  op_mode;
    logic [7:0]  rate_msb;
    logic [7:0]  rate_lsb;
    logic [7:0]  bit_rate_fraction;
    logic [7:0]  flags;
    logic [7:0]  calibration_temperature;
    logic [20:0] rate_acc;

    // address decode, one-hot write selects
    wire wr_en      = clk_en & wr_stb;
    wire rd_en      = clk_en & rd_stb;
    wire sel_data   = (addr == ADR_DATA_PORT);
    wire sel_mode   = (addr == ADR_OP_MODE);
    wire sel_flags  = (addr == ADR_FLAGS);
    wire sel_frac   = (addr == ADR_RATE_FRAC);
    wire wr_mode    = wr_en & sel_mode;
    wire wr_flags   = wr_en & sel_flags;

    // modulation field; reserved codes are stored but touch nothing else
    wire [1:0] next_mod   = wr_data[MOD_HI:MOD_LO];
    // unused bit 7 masked off on write
    wire [7:0] next_op_mode = wr_data & OP_MODE_MASK;

    // read multiplexer; unmapped and test area read zero
    logic [7:0] read_mux;
    always_comb begin
        case (addr)
            ADR_DATA_PORT:    read_mux = rx_byte;
            ADR_OP_MODE:      read_mux = op_mode;
            ADR_RATE_MSB:     read_mux = rate_msb;
            ADR_RATE_LSB:     read_mux = rate_lsb;
            ADR_FLAGS:        read_mux = flags;
            ADR_PIN_MAP_LO:   read_mux = pin_map_low;
            ADR_PIN_MAP_HI:   read_mux = pin_map_high_clock_out;
            ADR_REVISION:     read_mux = REVISION_CODE;
            ADR_GAIN_REF:     read_mux = gain_control_reference;
            ADR_GAIN_THR1:    read_mux = gain_threshold_one;
            ADR_GAIN_THR2:    read_mux = gain_threshold_two;
            ADR_GAIN_THR3:    read_mux = gain_threshold_three;
            ADR_REF_SELECT:   read_mux = reference_input_select;
            ADR_HP_AMP:       read_mux = high_power_amp_setting;
            ADR_SYNTH_BW:     read_mux = synth_loop_bandwidth;
            ADR_LOW_NOISE_BW: read_mux = low_noise_loop_bandwidth;
            ADR_CAL_TEMP:     read_mux = calibration_temperature;
            ADR_RATE_FRAC:    read_mux = bit_rate_fraction;
            default:          read_mux = ZERO_BYTE;
        endcase
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= ZERO_BYTE;
        end else if (clk_en) begin
            rd_data <= rd_stb ? read_mux : ZERO_BYTE;
        end
    end

    // data port: write pushes one byte, read pops one byte
    // these and the mode write are the pulse-triggering accesses of the bank
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tx_push <= 1'b0;
            tx_byte <= ZERO_BYTE;
            rx_pop  <= 1'b0;
        end else if (clk_en) begin
            tx_push <= wr_stb & sel_data;
            rx_pop  <= rd_stb & sel_data;
            if (wr_stb & sel_data) begin
                tx_byte <= wr_data;
            end
        end
    end

    // mode write also pulses mode_written so the sequencer restarts
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            op_mode      <= RST_OP_MODE;
            mode_written <= 1'b0;
        end else if (clk_en) begin
            mode_written <= wr_stb & sel_mode;
            if (wr_mode) begin
                op_mode <= next_op_mode;
            end
        end
    end

    // shaping meaning depends on modulation, decoded downstream
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            modulation_kind      <= TURB_MOD_FSK;
            pulse_shaping_select <= RST_OP_MODE[SHAPE_HI:SHAPE_LO];
            xcvr_mode            <= RST_OP_MODE[MODE_HI:MODE_LO];
        end else if (clk_en && wr_mode) begin
            modulation_kind      <= next_mod;
            pulse_shaping_select <= wr_data[SHAPE_HI:SHAPE_LO];
            xcvr_mode            <= wr_data[MODE_HI:MODE_LO];
        end
    end

    // plain configuration registers, all reloaded at reset
    // test area has no storage, so stray writes cannot disturb it
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_msb                 <= RST_RATE_MSB;
            rate_lsb                 <= RST_RATE_LSB;
            pin_map_low              <= RST_PIN_MAP;
            pin_map_high_clock_out   <= RST_PIN_MAP;
            gain_control_reference   <= RST_GAIN_REF;
            gain_threshold_one       <= RST_GAIN_THR1;
            gain_threshold_two       <= RST_GAIN_THR2;
            gain_threshold_three     <= RST_GAIN_THR3;
            reference_input_select   <= RST_REF_SELECT;
            high_power_amp_setting   <= RST_HP_AMP;
            synth_loop_bandwidth     <= RST_PLL_BW;
            low_noise_loop_bandwidth <= RST_PLL_BW;
            bit_rate_fraction        <= RST_RATE_FRAC;
        end else if (wr_en) begin
            case (addr)
                ADR_RATE_MSB:     rate_msb                 <= wr_data;
                ADR_RATE_LSB:     rate_lsb                 <= wr_data;
                ADR_PIN_MAP_LO:   pin_map_low              <= wr_data;
                ADR_PIN_MAP_HI:   pin_map_high_clock_out   <= wr_data;
                ADR_GAIN_REF:     gain_control_reference   <= wr_data;
                ADR_GAIN_THR1:    gain_threshold_one       <= wr_data;
                ADR_GAIN_THR2:    gain_threshold_two       <= wr_data;
                ADR_GAIN_THR3:    gain_threshold_three     <= wr_data;
                ADR_REF_SELECT:   reference_input_select   <= wr_data;
                ADR_HP_AMP:       high_power_amp_setting   <= wr_data;
                ADR_SYNTH_BW:     synth_loop_bandwidth     <= wr_data;
                ADR_LOW_NOISE_BW: low_noise_loop_bandwidth <= wr_data;
                // fraction keeps only its four live bits
                ADR_RATE_FRAC:    bit_rate_fraction        <= wr_data & FRAC_MASK;
                default:          ;
            endcase
        end
    end

    // capture temperature at each calibration run; read-only to host
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            calibration_temperature <= RST_CAL_TEMP;
        end else if (clk_en && cal_done) begin
            calibration_temperature <= cal_temp_in;
        end
    end

    // status flags: live bits follow inputs, sticky bits hold
    // a set arriving with the write-one clear wins, so no event is lost
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_flag
            wire clr = wr_flags & wr_data[gi];
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    flags[gi] <= RST_FLAGS[gi];
                end else if (clk_en) begin
                    if (!FLG_STICKY[gi]) begin
                        flags[gi] <= flag_in[gi];
                    end else if (flag_in[gi]) begin
                        flags[gi] <= 1'b1;
                    end else if (clr) begin
                        flags[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // accumulator in sixteenths: period = 16*divisor + fraction
    // a zero divisor would tick every cycle rather than stall
    wire [20:0] period16  = {1'b0, rate_msb, rate_lsb, 4'h0} +
                            {17'h00000, bit_rate_fraction[3:0]};
    wire [20:0] acc_sum   = rate_acc + ACC_STEP;
    wire        acc_wrap  = (acc_sum >= period16);
    wire [20:0] next_acc  = acc_wrap ? (acc_sum - period16) : acc_sum;
    // a divisor or fraction write restarts the count; a large stale accumulator
    // would otherwise tick every cycle for a long time after a speed-up
    wire        rate_wr   = wr_en & ((addr == ADR_RATE_MSB) | (addr == ADR_RATE_LSB) | sel_frac);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rate_acc <= 21'h000000;
            bit_tick <= 1'b0;
        end else if (clk_en) begin
            rate_acc <= rate_wr ? {ACC_W{1'b0}} : next_acc;
            bit_tick <= acc_wrap;
        end
    end

    // checks on the behaviour above
    sequence s_wr_mode;
        clk_en && wr_stb && sel_mode;
    endsequence

    sequence s_mode_out;
        modulation_kind == $past(wr_data[MOD_HI:MOD_LO]) &&
        xcvr_mode == $past(wr_data[MODE_HI:MODE_LO]);
    endsequence

    chk_mode_write_lands: assert property (
        @(posedge clk) disable iff (!rst_b) s_wr_mode |=> s_mode_out)
        else $error("mode fields did not follow the write");

    chk_shape_write_lands: assert property (
        @(posedge clk) disable iff (!rst_b)
        s_wr_mode |=> pulse_shaping_select == $past(wr_data[SHAPE_HI:SHAPE_LO]))
        else $error("shaping field did not follow the write");

    chk_push_pulse_data: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && wr_stb && sel_data) |=> tx_push && tx_byte == $past(wr_data))
        else $error("data port write did not push the byte");

    chk_pop_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && rd_stb && sel_data) ##1 clk_en |=> !rx_pop || $past(rd_stb && sel_data))
        else $error("pop pulse held beyond its read");

    chk_rev_readback: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && rd_stb && addr == ADR_REVISION) |=> rd_data == REVISION_CODE)
        else $error("revision code read back wrong");

    chk_sticky_set_wins: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && flag_in[FLG_OVERRUN]) |=> flags[FLG_OVERRUN])
        else $error("overrun flag lost its set");

    chk_cal_temp_capture: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && cal_done) |=> calibration_temperature == $past(cal_temp_in))
        else $error("calibration temperature not captured");

    chk_frac_masked: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_en && sel_frac) |=> bit_rate_fraction == ($past(wr_data) & FRAC_MASK))
        else $error("fraction register kept unused bits");

    chk_tick_spacing: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && bit_tick && rate_msb == ZERO_BYTE && rate_lsb == 8'h02 &&
         bit_rate_fraction == ZERO_BYTE && $stable(rate_lsb))
        ##1 clk_en |-> !bit_tick)
        else $error("bit tick came early for divisor two");

    chk_read_zero_after: assert property (
        @(posedge clk) disable iff (!rst_b)
        (clk_en && !rd_stb) |=> rd_data == ZERO_BYTE)
        else $error("read data stood beyond its cycle");

    chk_sticky_clear: assert property (
        @(posedge clk) disable iff (!rst_b)
        (wr_flags && wr_data[FLG_OVERRUN] && !flag_in[FLG_OVERRUN]) |=> !flags[FLG_OVERRUN])
        else $error("overrun flag ignored its clear");

    chk_rate_restart: assert property (
        @(posedge clk) disable iff (!rst_b)
        rate_wr |=> rate_acc == {ACC_W{1'b0}})
        else $error("bit clock did not restart on a rate write");
endmodule // turb_regs
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking testbench for the upper register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import turb_pkg::*;
    logic            clk;
    logic            rst_b;
    logic            clk_en;
    logic            cal_done;
    logic      [6:0] addr;
    logic      [7:0] wr_data, rd_data, rx_byte, flag_in, cal_temp_in, tx_byte;
    logic            wr_stb, rd_stb, tx_push, rx_pop, mode_written, bit_tick;
    logic      [1:0] mod_k, shape;
    logic      [2:0] xmode;
    wire logic [9:0][7:0] port_v;
    int              n_errors, n_compared, n_push, n_pop, n_mode, n_tick;
    // the ten port_v registers first, in the same order as port_v
    logic [6:0] ra [17] = '{ADR_PIN_MAP_LO, ADR_PIN_MAP_HI, ADR_GAIN_REF, ADR_GAIN_THR1,
        ADR_GAIN_THR2, ADR_GAIN_THR3, ADR_REF_SELECT, ADR_HP_AMP, ADR_SYNTH_BW,
        ADR_LOW_NOISE_BW, ADR_OP_MODE, ADR_RATE_MSB, ADR_RATE_LSB, ADR_FLAGS,
        ADR_REVISION, ADR_CAL_TEMP, ADR_RATE_FRAC};
    logic [7:0] rv [17] = '{RST_PIN_MAP, RST_PIN_MAP, RST_GAIN_REF, RST_GAIN_THR1,
        RST_GAIN_THR2, RST_GAIN_THR3, RST_REF_SELECT, RST_HP_AMP, RST_PLL_BW, RST_PLL_BW,
        RST_OP_MODE, RST_RATE_MSB, RST_RATE_LSB, RST_FLAGS, REVISION_CODE, RST_CAL_TEMP,
        RST_RATE_FRAC};

    turb_host_model i_host (.clk(clk), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rd_data(rd_data));

    turb_regs i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .addr(addr),
        .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
        .tx_push(tx_push), .tx_byte(tx_byte), .rx_pop(rx_pop), .rx_byte(rx_byte),
        .flag_in(flag_in), .cal_done(cal_done), .cal_temp_in(cal_temp_in),
        .modulation_kind(mod_k), .pulse_shaping_select(shape), .xcvr_mode(xmode),
        .mode_written(mode_written), .pin_map_low(port_v[0]),
        .pin_map_high_clock_out(port_v[1]), .gain_control_reference(port_v[2]),
        .gain_threshold_one(port_v[3]), .gain_threshold_two(port_v[4]),
        .gain_threshold_three(port_v[5]), .reference_input_select(port_v[6]),
        .high_power_amp_setting(port_v[7]), .synth_loop_bandwidth(port_v[8]),
        .low_noise_loop_bandwidth(port_v[9]), .bit_tick(bit_tick));

    // clock at 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // pulse counters sample pre-edge values, so no race with the design
    always @(posedge clk) begin
        if (tx_push === 1'b1) n_push++;
        if (rx_pop === 1'b1) n_pop++;
        if (mode_written === 1'b1) n_mode++;
        if (bit_tick === 1'b1) n_tick++;
    end

    task automatic complete_run();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", w, e, g);
        end
    endtask

    task automatic rdc(input logic [6:0] a, input logic [7:0] e, input string w);
        logic [7:0] d;
        i_host.rd(a, d);
        chk(w, e, d);
    endtask

    task automatic t_reset_values();
        for (int i = 0; i < 17; i++) begin
            rdc(ra[i], rv[i], "reset value");
        end
    endtask

    task automatic t_rw();
        for (int i = 0; i < 10; i++) begin
            i_host.wr(ra[i], 8'(8'h3c + i * 8'h11));
            rdc(ra[i], 8'(8'h3c + i * 8'h11), "readback");
            chk("config port", 8'(8'h3c + i * 8'h11), port_v[i]);
        end
        i_host.wr(ADR_REVISION, 8'hff);
        i_host.wr(ADR_CAL_TEMP, 8'hff);
        i_host.wr(7'h04, 8'hff);
        rdc(ADR_REVISION, REVISION_CODE, "revision");
        rdc(ADR_CAL_TEMP, RST_CAL_TEMP, "read-only temp");
        rdc(7'h04, ZERO_BYTE, "unmapped");
    endtask

    task automatic t_op_mode();
        logic [7:0] d;
        int         nm;
        for (int i = 0; i < 16; i++) begin
            d  = {1'b1, 2'(i >> 2), 2'(i), 3'(i)};
            nm = n_mode;
            i_host.wr(ADR_OP_MODE, d);
            #1;
            chk("modulation", {6'h00, d[6:5]}, {6'h00, mod_k});
            chk("shaping", {6'h00, d[4:3]}, {6'h00, shape});
            chk("xcvr mode", {5'h00, d[2:0]}, {5'h00, xmode});
            rdc(ADR_OP_MODE, {1'b0, d[6:0]}, "mode readback");
            chk("mode pulses", 8'h01, 8'(n_mode - nm));
        end
    endtask

    task automatic t_data_port();
        int np;
        int nr;
        np = n_push;
        nr = n_pop;
        rx_byte <= 8'h3c;
        i_host.wr(ADR_DATA_PORT, 8'haa);
        #1;
        chk("tx byte", 8'haa, tx_byte);
        i_host.wr(ADR_DATA_PORT, 8'h55);
        #1;
        chk("tx byte", 8'h55, tx_byte);
        rdc(ADR_DATA_PORT, 8'h3c, "rx byte");
        // let the pulse counters finish this edge before reading them
        #1;
        chk("push pulses", 8'h02, 8'(n_push - np));
        chk("pop pulses", 8'h01, 8'(n_pop - nr));
    endtask

    task automatic t_flags();
        @(posedge clk);
        flag_in <= 8'h50;
        // clear arrives while the overrun input is still high: set must win
        i_host.wr(ADR_FLAGS, 8'h10);
        flag_in <= 8'h40;
        rdc(ADR_FLAGS, 8'h50, "sticky overrun");
        i_host.wr(ADR_FLAGS, 8'h10);
        rdc(ADR_FLAGS, 8'h40, "overrun cleared");
        flag_in <= 8'h80;
        rdc(ADR_FLAGS, 8'h80, "live full flag");
        flag_in <= 8'h40;
    endtask

    task automatic t_cal();
        @(posedge clk);
        cal_temp_in <= 8'h37;
        cal_done    <= 1'b1;
        @(posedge clk);
        cal_done    <= 1'b0;
        cal_temp_in <= 8'h99;
        rdc(ADR_CAL_TEMP, 8'h37, "captured temp");
    endtask

    task automatic t_rate();
        int nt;
        i_host.wr(ADR_RATE_MSB, 8'h00);
        i_host.wr(ADR_RATE_LSB, 8'h02);
        // counters are read between edges so they never race the counting process
        #401;
        nt = n_tick;
        #4000;
        chk("ticks whole", 8'h14, 8'(n_tick - nt));
        i_host.wr(ADR_RATE_FRAC, 8'hf8);
        rdc(ADR_RATE_FRAC, 8'h08, "fraction");
        #1;
        nt = n_tick;
        #8000;
        nt = n_tick - nt;
        chk("ticks fraction", 8'h01, {7'h00, nt >= 31 && nt <= 33});
    endtask

    task automatic t_clk_en();
        @(posedge clk);
        clk_en <= 1'b0;
        i_host.wr(ADR_PIN_MAP_LO, 8'h77);
        @(posedge clk);
        clk_en <= 1'b1;
        rdc(ADR_PIN_MAP_LO, 8'h3c, "frozen write");
    endtask

    task automatic t_reset_mid();
        @(posedge clk);
        rst_b <= 1'b0;
        #1;
        chk("async reset", RST_PIN_MAP, port_v[1]);
        @(posedge clk);
        rst_b <= 1'b1;
        rdc(ADR_PIN_MAP_HI, RST_PIN_MAP, "after reset");
        rdc(ADR_OP_MODE, RST_OP_MODE, "mode after reset");
    endtask

    // main sequence; reset held for two cycles
    initial begin
        rst_b       = 1'b0;
        clk_en      = 1'b1;
        cal_done    = 1'b0;
        cal_temp_in = 8'h00;
        rx_byte     = 8'h00;
        flag_in     = 8'h40;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_reset_values();
        // configuration is rewritten before any transmit or receive mode is set
        t_rw();
        t_op_mode();
        t_data_port();
        t_flags();
        t_cal();
        t_rate();
        t_clk_en();
        t_reset_mid();
        complete_run();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule // tb
`default_nettype wire

// *** testbench/turb_host_model.sv ***
// host side model: single-cycle register bus master for the register bank
`timescale 1ns/1ps
`default_nettype none
module turb_host_model
    import turb_pkg::*;
(
    input  wire logic       clk,
    output logic      [6:0] addr,
    output logic      [7:0] wr_data,
    output logic            wr_stb,
    output logic            rd_stb,
    input  wire logic [7:0] rd_data
);
    // idle bus at time zero, both strobes low
    initial begin
        addr    = 7'h00;
        wr_data = 8'h00;
        wr_stb  = 1'b0;
        rd_stb  = 1'b0;
    end

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        if (a > 7'h46 && a < 7'h58) begin
            return;
        end
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_stb  <= 1'b1;
        @(posedge clk);
        wr_stb  <= 1'b0;
        addr    <= ~a;  // released lines show the inverse, never a stale value
        wr_data <= ~d;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr   <= ~a;
        @(posedge clk);
        d = rd_data;  // taken before this edge's updates land
    endtask
endmodule // turb_host_model
`default_nettype wire
